// ==== core/acttc_regs.vh ====
// acttc_regs.vh: register offsets, field positions, reset values and timing counts
// assumes a 10 MHz core clock (100 ns period) and 32-bit Avalon-MM word addressing by byte
`ifndef ACTTC_REGS_VH
`define ACTTC_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACTTC_OFS_CTRL      8'h00
`define ACTTC_OFS_STATUS    8'h04
`define ACTTC_OFS_IRQ_STAT  8'h08
`define ACTTC_OFS_IRQ_MASK  8'h0C
`define ACTTC_OFS_RESULT    8'h10
`define ACTTC_OFS_ALERT_THR 8'h14

// ----------------------------------------
// control fields
// ----------------------------------------
`define ACTTC_CTRL_AUTO_BIT   0
`define ACTTC_CTRL_BUSY_EN    1
`define ACTTC_CTRL_ALERT_EN   2
`define ACTTC_CTRL_SWRST_BIT  3
`define ACTTC_CTRL_CODE_LSB   4
`define ACTTC_CTRL_CODE_MSB   6
`define ACTTC_CTRL_RESET      7'h00

// ----------------------------------------
// status / interrupt bits
// ----------------------------------------
`define ACTTC_EV_DONE    0
`define ACTTC_EV_ALERT   1
`define ACTTC_EV_READY   2
`define ACTTC_EV_W       3

// ----------------------------------------
// timing in ns or us and derived cycle counts at 100 ns per cycle
// ----------------------------------------
`define ACTTC_CLK_NS          100
`define ACTTC_CONVERT_NS      415
`define ACTTC_CONVERT_CYC     ((`ACTTC_CONVERT_NS + `ACTTC_CLK_NS - 1) / `ACTTC_CLK_NS)
`define ACTTC_ALERT_NS        425
`define ACTTC_ALERT_CYC       (`ACTTC_ALERT_NS / `ACTTC_CLK_NS)
`define ACTTC_RECOVER_US      310
`define ACTTC_RECOVER_CYC     ((`ACTTC_RECOVER_US * 1000 + `ACTTC_CLK_NS - 1) / `ACTTC_CLK_NS)
// typical self-timed period for code 0x0, in us; other codes scale from it
`define ACTTC_AUTO_BASE_US    10
`define ACTTC_AUTO_BASE_CYC   ((`ACTTC_AUTO_BASE_US * 1000) / `ACTTC_CLK_NS)

`endif

// ==== core/acttc_edge_sync.v ====
// acttc_edge_sync.v: two-flop synchroniser with rising-edge pulse
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module acttc_edge_sync (
	// clock and reset
	input  wire clk,
	input  wire reset_n,
	// asynchronous level in
	input  wire async_in,
	// synchronised level and rising-edge pulse
	output wire level,
	output wire rise
);
	reg meta_ff;
	reg sync_ff;
	reg last_ff;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise  = sync_ff & ~last_ff;
endmodule

// ==== core/acttc_top.v ====
// acttc_top.v: conversion timing control with Avalon-MM register slave
// assumes one 10 MHz clock, conversion_start arrives from a pin and is synchronised here
// Function
// - self-timed period from 3-bit code, 10..800 us
// - busy stays low between self-timed conversions
// - busy rises promptly after conversion start edge
// - alert updated at conversion end, 5 cycles (500 ns) after busy rises, not within 425 ns of start
// - 310 us recovery after software reset, one cycle after RESET_N; no access
`timescale 1ns/1ps
`include "acttc_regs.vh"
module acttc_top #(
	parameter RECOVER_CYC   = `ACTTC_RECOVER_CYC,
	parameter AUTO_BASE_CYC = `ACTTC_AUTO_BASE_CYC
) (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        RESET_N,
	// Avalon-MM slave
	input  wire [7:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	// conversion pins
	input  wire        CONVERSION_START,
	input  wire [15:0] SAMPLE_DATA,
	output reg         BUSY,
	output reg         ALERT,
	output reg         IRQ
);
	// ----------------------------------------
	// local state
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_WAIT = 2'h2;

	reg [1:0]  state_ff;
	reg [1:0]  nxt_state;
	reg [6:0]  ctrl_ff;
	reg [2:0]  irq_stat_ff;
	reg [2:0]  irq_mask_ff;
	reg [15:0] result_ff;
	reg [15:0] thr_ff;
	reg [31:0] cnt_ff;
	reg [31:0] nxt_cnt;
	reg [31:0] rec_ff;
	reg [31:0] period_cyc;
	reg [15:0] smp_meta_ff;
	reg [15:0] smp_sync_ff;
	reg        ack_ff;

	wire       start_lvl;
	wire       start_rise;
	wire       recovering = (rec_ff != 32'h0);
	wire       auto_mode  = ctrl_ff[`ACTTC_CTRL_AUTO_BIT];
	wire [2:0] code       = ctrl_ff[`ACTTC_CTRL_CODE_MSB:`ACTTC_CTRL_CODE_LSB];
	wire       is_ctrl    = (AVS_ADDRESS == `ACTTC_OFS_CTRL);
	wire       do_wr      = AVS_WRITE & ~AVS_WAITREQUEST;
	wire       accept     = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & ~ack_ff & ~recovering;
	wire       rd_take    = accept & AVS_READ;
	wire       swrst      = do_wr & is_ctrl & AVS_BYTEENABLE[0] & AVS_WRITEDATA[`ACTTC_CTRL_SWRST_BIT];
	wire       done_ev    = (state_ff == ST_CONV) && (cnt_ff == 32'h1);
	wire       alert_now  = (smp_sync_ff > thr_ff);
	wire [2:0] events;

	acttc_edge_sync u_start_sync (
		.clk      (CORE_CLK),
		.reset_n  (RESET_N),
		.async_in (CONVERSION_START),
		.level    (start_lvl),
		.rise     (start_rise)
	);

	// ----------------------------------------
	// sample bus capture
	// ----------------------------------------
	// the bus is settled long before conversion end, so two flops only add latency
	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			smp_meta_ff <= 16'h0000;
			smp_sync_ff <= 16'h0000;
		end else begin
			smp_meta_ff <= SAMPLE_DATA;
			smp_sync_ff <= smp_meta_ff;
		end
	end

	// ----------------------------------------
	// self-timed period per code
	// ----------------------------------------
	// codes 0..3 double from the base, 4..7 double from ten times the base
	always @* begin
		case (code)
			3'h0:    period_cyc = AUTO_BASE_CYC;
			3'h1:    period_cyc = AUTO_BASE_CYC * 2;
			3'h2:    period_cyc = AUTO_BASE_CYC * 4;
			3'h3:    period_cyc = AUTO_BASE_CYC * 8;
			3'h4:    period_cyc = AUTO_BASE_CYC * 10;
			3'h5:    period_cyc = AUTO_BASE_CYC * 20;
			3'h6:    period_cyc = AUTO_BASE_CYC * 40;
			default: period_cyc = AUTO_BASE_CYC * 80;
		endcase
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (!recovering && (auto_mode || start_rise)) begin
					nxt_state = ST_CONV;
					nxt_cnt   = `ACTTC_CONVERT_CYC;
				end
			end
			ST_CONV: begin
				if (cnt_ff > 32'h1) begin
					nxt_cnt = cnt_ff - 32'h1;
				end else if (auto_mode) begin
					// remaining time of the period keeps busy low
					nxt_state = ST_WAIT;
					nxt_cnt   = period_cyc - `ACTTC_CONVERT_CYC;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (!auto_mode) begin
					nxt_state = ST_IDLE;
				end else if (cnt_ff > 32'h1) begin
					nxt_cnt = cnt_ff - 32'h1;
				end else begin
					nxt_state = ST_CONV;
					nxt_cnt   = `ACTTC_CONVERT_CYC;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// recovery-finished fires in the last recovery cycle
	assign events = {(rec_ff == 32'h1), done_ev & alert_now, done_ev};

	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 32'h0;
			rec_ff   <= 32'h1;
			result_ff <= 16'h0000;
			BUSY     <= 1'b0;
			ALERT    <= 1'b0;
		end else if (swrst) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 32'h0;
			rec_ff   <= RECOVER_CYC;
			BUSY     <= 1'b0;
		end else begin
			if (rec_ff != 32'h0) begin
				rec_ff <= rec_ff - 32'h1;
			end
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			// busy high only during conversion, low while waiting
			BUSY <= ctrl_ff[`ACTTC_CTRL_BUSY_EN] & (nxt_state == ST_CONV);
			if (done_ev) begin
				result_ff <= smp_sync_ff;
				ALERT     <= ctrl_ff[`ACTTC_CTRL_ALERT_EN] & alert_now;
			end
		end
	end

	// ----------------------------------------
	// Avalon-MM slave and interrupts
	// ----------------------------------------
	// one wait cycle per access; refused (held in wait) while recovering
	always @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0;
			ack_ff          <= 1'b0;
			ctrl_ff         <= `ACTTC_CTRL_RESET;
			irq_mask_ff     <= 3'h0;
			irq_stat_ff     <= 3'h0;
			thr_ff          <= 16'hFFFF;
			IRQ             <= 1'b0;
		end else begin
			ack_ff          <= accept;
			AVS_WAITREQUEST <= ~accept;
			if (do_wr && AVS_BYTEENABLE[0]) begin
				case (AVS_ADDRESS)
					`ACTTC_OFS_CTRL:      ctrl_ff     <= {AVS_WRITEDATA[6:4], 1'b0, AVS_WRITEDATA[2:0]};
					`ACTTC_OFS_IRQ_MASK:  irq_mask_ff <= AVS_WRITEDATA[2:0];
					`ACTTC_OFS_ALERT_THR: thr_ff[7:0] <= AVS_WRITEDATA[7:0];
					default:              ctrl_ff     <= ctrl_ff;
				endcase
			end
			if (do_wr && AVS_BYTEENABLE[1] && AVS_ADDRESS == `ACTTC_OFS_ALERT_THR) begin
				thr_ff[15:8] <= AVS_WRITEDATA[15:8];
			end
			// read data stands in the cycle waitrequest is low
			if (rd_take) begin
				case (AVS_ADDRESS)
					`ACTTC_OFS_CTRL:      AVS_READDATA <= {25'h0, ctrl_ff};
					`ACTTC_OFS_STATUS:    AVS_READDATA <= {28'h0, recovering, ALERT, BUSY, start_lvl};
					`ACTTC_OFS_IRQ_STAT:  AVS_READDATA <= {29'h0, irq_stat_ff};
					`ACTTC_OFS_IRQ_MASK:  AVS_READDATA <= {29'h0, irq_mask_ff};
					`ACTTC_OFS_RESULT:    AVS_READDATA <= {16'h0, result_ff};
					`ACTTC_OFS_ALERT_THR: AVS_READDATA <= {16'h0, thr_ff};
					default:              AVS_READDATA <= 32'h0;
				endcase
			end else begin
				AVS_READDATA <= 32'h0;
			end
			// set wins over the clear-on-read
			if (rd_take && AVS_ADDRESS == `ACTTC_OFS_IRQ_STAT) begin
				irq_stat_ff <= events;
			end else begin
				irq_stat_ff <= irq_stat_ff | events;
			end
			IRQ <= |((irq_stat_ff | events) & irq_mask_ff);
		end
	end
endmodule

// ==== dv/acttc_asserts.sv ====
// acttc_asserts.sv: port checker for acttc_top
// assumes one clock domain; bound to every acttc_top
`timescale 1ns/1ps
module acttc_asserts (
	// watched ports
	input wire        CORE_CLK,
	input wire        RESET_N,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	input wire        BUSY,
	input wire        ALERT
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);
	// ----------------
	// conversion and bus checks
	// ----------------
	sequence s_conv; BUSY [*5] ##1 !BUSY; endsequence
	sequence s_answer; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
	property p_busy_hold; $rose(BUSY) |-> s_conv; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy width wrong");
	property p_busy_gap; $fell(BUSY) |-> !BUSY [*3]; endproperty
	a_busy_gap: assert property (p_busy_gap) else $error("busy gap short");
	property p_alert_end; $changed(ALERT) |-> $fell(BUSY); endproperty
	a_alert_end: assert property (p_alert_end) else $error("alert off conversion end");
	property p_wait_one; $fell(AVS_WAITREQUEST) |-> s_answer; endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer not one cycle");
	property p_wait_cause; !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	property p_rdata_idle; AVS_WAITREQUEST |-> AVS_READDATA == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
endmodule
bind acttc_top acttc_asserts i_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.BUSY(BUSY), .ALERT(ALERT));

// ==== dv/acttc_host_model.sv ====
// acttc_host_model.sv: host driving the start pin and the result bus
// assumes go is a one-cycle pulse given only while idle is high
`timescale 1ns/1ps
module acttc_host_model (
	// clock and bench request
	input  wire        clk,
	input  wire        go,
	input  wire [15:0] value,
	// pins toward the block
	output reg         start_ff = 1'b0,
	output reg  [15:0] sample_ff = 16'h0,
	output wire        idle
);
	// ----------------
	// start pulse and spacing
	// ----------------
	reg [4:0] gap_ff = 5'h0;
	assign idle = (gap_ff == 5'h0);
	always @(posedge clk) begin
		if (go) begin
			start_ff  <= 1'b1;
			sample_ff <= value;
			gap_ff    <= 5'h14;
		end else if (!idle) begin
			gap_ff <= gap_ff - 5'h1;
			if (gap_ff == 5'h12) begin
				start_ff <= 1'b0;
			end
		end
	end
endmodule

// ==== dv/test_adc_conversion_timing_control.sv ====
// test_adc_conversion_timing_control.sv: self-checking bench for acttc_top
// assumes acttc_regs.vh on the include path and the host model beside it
`timescale 1ns/1ps
`include "acttc_regs.vh"
module test_adc_conversion_timing_control;
	localparam REC  = 20;
	localparam BASE = 10;
	// power-up and setup waits, scaled to bench time
	localparam POR  = 4;
	reg         clk, rst_n, rd, wr, go;
	reg  [7:0]  adr;
	reg  [31:0] wd, d;
	reg  [15:0] val, thr;
	wire [31:0] rdat;
	wire [15:0] smp;
	wire        wreq, busy, alert, irq, pin, idle;
	integer     fail_count, n_compared, n, a, i;
	acttc_top #(.RECOVER_CYC(REC), .AUTO_BASE_CYC(BASE)) i_dut (.CORE_CLK(clk), .RESET_N(rst_n),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .CONVERSION_START(pin), .SAMPLE_DATA(smp),
		.BUSY(busy), .ALERT(alert), .IRQ(irq));
	acttc_host_model i_host (.clk(clk), .go(go), .value(val), .start_ff(pin), .sample_ff(smp), .idle(idle));
	// ----------------
	// helpers
	// ----------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function integer mult(input [2:0] c);
		mult = (c < 3'h4) ? (1 << c) : 10 * (1 << (c - 3'h4));
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task tmo;
		fail_count = fail_count + 1;
		$display("ERROR %0t: timeout", $time);
		end_of_test;
	endtask
	task bus(input w, input [7:0] ad, input [31:0] v);
		@(posedge clk);
		rd  <= ~w;
		wr  <= w;
		adr <= ad;
		wd  <= v;
		n = 0;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 9000) begin
			@(posedge clk);
			n = n + 1;
		end
		if (n >= 9000) tmo;
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task wait_busy(input lvl);
		n = 0;
		while (busy !== lvl && n < 9000) begin
			@(negedge clk);
			n = n + 1;
		end
		if (n >= 9000) tmo;
	endtask
	task start(input [15:0] v);
		a = 0;
		while (idle !== 1'b1 && a < 99) begin
			@(posedge clk);
			a = a + 1;
		end
		if (a >= 99) tmo;
		@(posedge clk);
		go  <= 1'b1;
		val <= v;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// ----------------
	// main sequence
	// ----------------
	initial begin
		rst_n = 1'b0; rd = 1'b0; wr = 1'b0; go = 1'b0; adr = 8'h00; wd = 32'h0; val = 16'h0;
		fail_count = 0;
		n_compared = 0;
		d = $urandom(5870);
		thr = $urandom % 32768;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (POR) @(posedge clk);
		bus(1'b0, `ACTTC_OFS_ALERT_THR, 32'h0);
		check(d, 32'h0000FFFF);
		bus(1'b0, 8'h20, 32'h0);
		check(d, 32'h0);
		bus(1'b1, `ACTTC_OFS_ALERT_THR, {16'h0, thr});
		bus(1'b1, `ACTTC_OFS_CTRL, 32'h6);
		for (i = 0; i < 6; i = i + 1) begin
			bus(1'b1, `ACTTC_OFS_IRQ_MASK, i % 2);
			start(i == 0 ? thr : i == 1 ? thr + 16'h1 : i == 5 ? 16'h0 : $urandom);
			wait_busy(1'b1);
			check(n <= 5, 1);
			wait_busy(1'b0);
			check(n, 5);
			check(alert, val > thr);
			@(negedge clk);
			check(irq, i % 2);
			bus(1'b0, `ACTTC_OFS_RESULT, 32'h0);
			check(d, {16'h0, val});
			bus(1'b0, `ACTTC_OFS_IRQ_STAT, 32'h0);
			check(d[0], 1'b1);
			repeat (2) @(negedge clk);
			check(irq, 1'b0);
		end
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b1, `ACTTC_OFS_CTRL, 32'h7 | (i << 4));
			wait_busy(1'b1);
			wait_busy(1'b0);
			wait_busy(1'b1);
			wait_busy(1'b0);
			a = n;
			wait_busy(1'b1);
			check(a + n, BASE * mult(i));
		end
		bus(1'b1, `ACTTC_OFS_CTRL, 32'h6);
		wait_busy(1'b0);
		bus(1'b1, `ACTTC_OFS_CTRL, 32'h8);
		bus(1'b0, `ACTTC_OFS_CTRL, 32'h0);
		check(n >= REC - 2, 1);
		check(d[3], 1'b0);
		bus(1'b0, `ACTTC_OFS_IRQ_STAT, 32'h0);
		check(d[2], 1'b1);
		end_of_test;
	end
endmodule
